// ==== shared/srfm_regs.vh ====
// Register addresses, widths and error codes of the shared RAM FIFO mailbox
`ifndef SRFM_REGS_VH
`define SRFM_REGS_VH
`define SRFM_NUM_QUEUES      4
`define SRFM_ADDR_U16_PORT   16'hb798
`define SRFM_ADDR_U32_PORT   16'hb7a2
`define SRFM_ADDR_I32_PORT   16'hb7ac
`define SRFM_ADDR_F32_PORT   16'hb7b6
`define SRFM_ADDR_CAPACITY   16'hbb1c
`define SRFM_ADDR_FILL       16'hbb26
`define SRFM_ADDR_FLUSH      16'hbb3a
`define SRFM_QUEUE_STRIDE    16'h0002
`define SRFM_BYTES_WIDE      3'h4
`define SRFM_BYTES_NARROW    3'h2
`define SRFM_ERR_NONE        2'h0
`define SRFM_ERR_UNDERRUN    2'h1
`define SRFM_ERR_OVERFLOW    2'h2
`define SRFM_ERR_UNMAPPED    2'h3
`endif

// ==== logic/srfm_queue_ram.v ====
// Byte-wide storage shared by all four queues, one region per queue
`timescale 1ns/1ps
module srfm_queue_ram #(
   parameter AW = 10
) (
   input  wire          ref_clk_i,
   input  wire          wr_en_i,
   input  wire [AW-1:0] wr_addr_i,
   input  wire [7:0]    wr_data_i,
   input  wire [AW-1:0] rd_addr_i,
   output wire [7:0]    rd_data_o
);
   reg [7:0] mem [0:(1<<AW)-1];

   always @(posedge ref_clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   assign rd_data_o = mem[rd_addr_i];
endmodule // srfm_queue_ram

// ==== logic/srfm_mailbox.v ====
// Four byte queues reached through typed 16/32-bit register ports
`timescale 1ns/1ps
`include "srfm_regs.vh"
module srfm_mailbox #(
   parameter SEG_AW = 8
) (
   input  wire        ref_clk_i,
   input  wire        rst_i,
   input  wire        req_i,
   input  wire        req_we_i,
   input  wire        req_dw_i,
   input  wire [15:0] req_addr_i,
   input  wire [31:0] req_wdata_i,
   output reg         ack_o,
   output reg  [31:0] rdata_o,
   output reg  [1:0]  err_o,
   output reg         busy_o
);
   localparam AW = SEG_AW + 2;
   localparam [SEG_AW:0] SEG_BYTES = {1'b1, {SEG_AW{1'b0}}};
   localparam ST_IDLE = 2'd0;
   localparam ST_MOVE = 2'd1;
   localparam ST_DONE = 2'd2;

   // Decoded register: 0..3 data ports, 4 capacity, 5 fill, 6 flush, 7 none
   function [2:0] reg_kind;
      input [15:0] a;
      begin
         if (a >= `SRFM_ADDR_U16_PORT && a < `SRFM_ADDR_U16_PORT + 16'h0008 && !a[0])
            reg_kind = 3'd0;
         else if (a >= `SRFM_ADDR_U32_PORT && a < `SRFM_ADDR_U32_PORT + 16'h0008 && !a[0])
            reg_kind = 3'd1;
         else if (a >= `SRFM_ADDR_I32_PORT && a < `SRFM_ADDR_I32_PORT + 16'h0008 && !a[0])
            reg_kind = 3'd2;
         else if (a >= `SRFM_ADDR_F32_PORT && a < `SRFM_ADDR_F32_PORT + 16'h0008 && !a[0])
            reg_kind = 3'd3;
         else if (a >= `SRFM_ADDR_CAPACITY && a < `SRFM_ADDR_CAPACITY + 16'h0008 && !a[0])
            reg_kind = 3'd4;
         else if (a >= `SRFM_ADDR_FILL && a < `SRFM_ADDR_FILL + 16'h0008 && !a[0])
            reg_kind = 3'd5;
         else if (a >= `SRFM_ADDR_FLUSH && a < `SRFM_ADDR_FLUSH + 16'h0008 && !a[0])
            reg_kind = 3'd6;
         else
            reg_kind = 3'd7;
      end
   endfunction

   // Base word address of each decoded register kind, used to find the queue index
   function [15:0] kind_base;
      input [2:0] k;
      begin
         case (k)
            3'd0:    kind_base = `SRFM_ADDR_U16_PORT;
            3'd1:    kind_base = `SRFM_ADDR_U32_PORT;
            3'd2:    kind_base = `SRFM_ADDR_I32_PORT;
            3'd3:    kind_base = `SRFM_ADDR_F32_PORT;
            3'd4:    kind_base = `SRFM_ADDR_CAPACITY;
            3'd5:    kind_base = `SRFM_ADDR_FILL;
            default: kind_base = `SRFM_ADDR_FLUSH;
         endcase
      end
   endfunction

   // Fill is one bit wider than the pointers so a full region reads back as its size
   reg [SEG_AW:0]   capacity [0:`SRFM_NUM_QUEUES-1];
   reg [SEG_AW:0]   fill     [0:`SRFM_NUM_QUEUES-1];
   reg [SEG_AW-1:0] head     [0:`SRFM_NUM_QUEUES-1];
   reg [SEG_AW-1:0] tail     [0:`SRFM_NUM_QUEUES-1];
   reg [1:0]        state;
   reg [1:0]        q;
   reg              is_write;
   reg [2:0]        nbytes;
   reg [2:0]        idx;
   reg [31:0]       shifter;
   reg              ram_we;
   reg [AW-1:0]     ram_waddr;
   reg [7:0]        ram_wdata;
   wire [7:0]       ram_rdata;
   wire [2:0]       kind = reg_kind(req_addr_i);
   wire [15:0]      base_off = req_addr_i - kind_base(kind);
   wire [1:0]       req_q = base_off[2:1];
   wire [2:0]       req_bytes = (kind == 3'd0) ? `SRFM_BYTES_NARROW : `SRFM_BYTES_WIDE;
   wire [SEG_AW+1:0] room_need = {1'b0, fill[req_q]} + {{(SEG_AW-1){1'b0}}, req_bytes};
   wire [AW-1:0]    rd_addr = {q, head[q]};
   integer          i;

   // Queue regions are fixed slices of one array; byte order is raw so any port type reads any data
   srfm_queue_ram #(.AW(AW)) u_ram (
      .ref_clk_i (ref_clk_i),
      .wr_en_i   (ram_we),
      .wr_addr_i (ram_waddr),
      .wr_data_i (ram_wdata),
      .rd_addr_i (rd_addr),
      .rd_data_o (ram_rdata)
   );

   // One access at a time; storage reads combinationally so a byte moves every cycle
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         state     <= ST_IDLE;
         ack_o     <= 1'b0;
         rdata_o   <= 32'h0000_0000;
         err_o     <= `SRFM_ERR_NONE;
         busy_o    <= 1'b0;
         q         <= 2'h0;
         is_write  <= 1'b0;
         nbytes    <= 3'h0;
         idx       <= 3'h0;
         shifter   <= 32'h0000_0000;
         ram_we    <= 1'b0;
         ram_waddr <= {AW{1'b0}};
         ram_wdata <= 8'h00;
         for (i = 0; i < `SRFM_NUM_QUEUES; i = i + 1) begin
            capacity[i] <= {(SEG_AW+1){1'b0}};
            fill[i]     <= {(SEG_AW+1){1'b0}};
            head[i]     <= {SEG_AW{1'b0}};
            tail[i]     <= {SEG_AW{1'b0}};
         end
      end else begin
         ack_o  <= 1'b0;
         ram_we <= 1'b0;
         case (state)
            ST_IDLE: begin
               // Hosts hold the request until they see ack; skipping the ack cycle keeps
               // that held request from being served twice
               if (req_i && !ack_o) begin
                  busy_o <= 1'b1;
                  err_o  <= `SRFM_ERR_NONE;
                  q      <= req_q;
                  state  <= ST_DONE;
                  if (kind <= 3'd3) begin
                     if (req_we_i && room_need > {1'b0, capacity[req_q]}) begin
                        // Nothing moves on overflow; the host sees the error and may retry
                        err_o <= `SRFM_ERR_OVERFLOW;
                     end else if (!req_we_i && fill[req_q] < {{(SEG_AW-2){1'b0}}, req_bytes}) begin
                        // Underrun reads return zero so stale data cannot pass for new
                        err_o   <= `SRFM_ERR_UNDERRUN;
                        rdata_o <= 32'h0000_0000;
                     end else begin
                        // Most significant byte first, matching word order on the bus
                        is_write <= req_we_i;
                        nbytes   <= req_bytes;
                        idx      <= 3'h0;
                        shifter  <= (kind == 3'd0) ? {req_wdata_i[15:0], 16'h0000} : req_wdata_i;
                        state    <= ST_MOVE;
                     end
                  end else if (kind == 3'd4) begin
                     if (req_we_i) begin
                        // Oversized requests clamp to the region; the host must budget memory
                        capacity[req_q] <= (req_wdata_i > {{(31-SEG_AW){1'b0}}, SEG_BYTES}) ?
                                           SEG_BYTES : req_wdata_i[SEG_AW:0];
                     end else begin
                        rdata_o <= {{(31-SEG_AW){1'b0}}, capacity[req_q]};
                     end
                  end else if (kind == 3'd5) begin
                     if (req_we_i)
                        err_o <= `SRFM_ERR_UNMAPPED;
                     else
                        rdata_o <= {{(31-SEG_AW){1'b0}}, fill[req_q]};
                  end else if (kind == 3'd6) begin
                     if (req_we_i) begin
                        fill[req_q] <= {(SEG_AW+1){1'b0}};
                        // Head jumps to tail, so discarded bytes are never read again
                        head[req_q] <= tail[req_q];
                     end else begin
                        err_o <= `SRFM_ERR_UNMAPPED;
                     end
                  end else begin
                     err_o <= `SRFM_ERR_UNMAPPED;
                  end
               end
            end
            ST_MOVE: begin
               if (is_write) begin
                  ram_we      <= 1'b1;
                  ram_waddr   <= {q, tail[q]};
                  ram_wdata   <= shifter[31:24];
                  shifter     <= {shifter[23:0], 8'h00};
                  tail[q]     <= tail[q] + {{(SEG_AW-1){1'b0}}, 1'b1};
                  fill[q]     <= fill[q] + {{SEG_AW{1'b0}}, 1'b1};
               end else begin
                  shifter     <= {shifter[23:0], ram_rdata};
                  head[q]     <= head[q] + {{(SEG_AW-1){1'b0}}, 1'b1};
                  fill[q]     <= fill[q] - {{SEG_AW{1'b0}}, 1'b1};
               end
               idx <= idx + 3'h1;
               if (idx + 3'h1 == nbytes) begin
                  state <= ST_DONE;
               end
            end
            ST_DONE: begin
               // Sixteen-bit reads come back zero-extended
               if (!is_write && err_o == `SRFM_ERR_NONE && nbytes != 3'h0) begin
                  rdata_o <= (nbytes == `SRFM_BYTES_NARROW) ? {16'h0000, shifter[15:0]} : shifter;
               end
               nbytes   <= 3'h0;
               is_write <= 1'b0;
               ack_o    <= 1'b1;
               busy_o   <= 1'b0;
               state    <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // srfm_mailbox

// ==== sim/srfm_host_model.sv ====
// Host that issues one register request at a time to the mailbox
`timescale 1ns/1ps
module srfm_host_model (
   input  wire        ref_clk_i,
   input  wire        ack_i,
   input  wire [31:0] rdata_i,
   input  wire [1:0]  err_i,
   output reg         req_o = 1'b0,
   output reg         we_o = 1'b0,
   output reg  [15:0] addr_o = 16'h0,
   output reg  [31:0] wdata_o = 32'h0
);
   // Whole 32-bit value moves in one request, never two word accesses
   task acc(input w, input [15:0] a, input [31:0] d, output [31:0] r, output [1:0] e);
      integer n;
      begin
         @(negedge ref_clk_i);
         req_o = 1'b1;
         we_o = w;
         addr_o = a;
         wdata_o = d;
         n = 0;
         while (ack_i !== 1'b1 && n < 20) begin
            @(negedge ref_clk_i);
            n = n + 1;
         end
         // Answer stands through the edge that samples ack; a missing ack yields unknowns
         r = (ack_i === 1'b1) ? rdata_i : 32'hxxxx_xxxx;
         e = (ack_i === 1'b1) ? err_i : 2'hx;
         @(negedge ref_clk_i);
         req_o = 1'b0;
         // Released lines show junk so stale values cannot pass for held ones
         addr_o = ~a;
         wdata_o = ~d;
      end
   endtask
endmodule // srfm_host_model

// ==== sim/srfm_mailbox_props.sv ====
// Port-level assertions for the mailbox
`timescale 1ns/1ps
`include "srfm_regs.vh"
module srfm_mailbox_props (
   input wire        ref_clk_i,
   input wire        rst_i,
   input wire        req_i,
   input wire        req_we_i,
   input wire        req_dw_i,
   input wire [15:0] req_addr_i,
   input wire [31:0] req_wdata_i,
   input wire        ack_o,
   input wire [31:0] rdata_o,
   input wire [1:0]  err_o,
   input wire        busy_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   wire take = req_i && !busy_o && !ack_o;
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
   busy_take_a: assert property (take |=> busy_o) else $error("request not taken");
   busy_end_a: assert property ($fell(busy_o) |-> ack_o) else $error("busy ended without ack");
   data_time_a: assert property (take && req_addr_i == `SRFM_ADDR_U32_PORT |-> ##[2:6] ack_o)
      else $error("data access late");
   cap_time_a: assert property (take && req_addr_i == `SRFM_ADDR_CAPACITY |-> ##2 ack_o)
      else $error("capacity access late");
   fill_ro_a: assert property (take && req_we_i && req_addr_i == `SRFM_ADDR_FILL
      |-> ##2 ack_o && err_o == `SRFM_ERR_UNMAPPED) else $error("fill write accepted");
   flush_wo_a: assert property (take && !req_we_i && req_addr_i == `SRFM_ADDR_FLUSH
      |-> ##2 ack_o && err_o == `SRFM_ERR_UNMAPPED) else $error("flush read accepted");
   under_zero_a: assert property (ack_o && err_o == `SRFM_ERR_UNDERRUN |-> rdata_o == 32'h0)
      else $error("underrun gave data");
   cover property (ack_o && err_o == `SRFM_ERR_OVERFLOW);
   cover property (ack_o && err_o == `SRFM_ERR_UNDERRUN);
   cover property (take && req_addr_i == `SRFM_ADDR_FLUSH);
endmodule // srfm_mailbox_props
bind srfm_mailbox srfm_mailbox_props u_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req_i),
   .req_we_i(req_we_i), .req_dw_i(req_dw_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
   .ack_o(ack_o), .rdata_o(rdata_o), .err_o(err_o), .busy_o(busy_o));

// ==== sim/tb_shared_ram_fifo_mailbox.sv ====
// Self-checking bench for the mailbox
`timescale 1ns/1ps
`include "srfm_regs.vh"
module tb_shared_ram_fifo_mailbox;
   reg         ref_clk_i = 1'b0;
   reg         rst_i = 1'b1;
   wire        req, we, ack, busy;
   wire [15:0] addr;
   wire [31:0] wd, rd;
   wire [1:0]  err;
   reg  [31:0] r;
   reg  [1:0]  e;
   integer     failures = 0;
   integer     n_tests = 0;
   integer     cyc = 0;
   srfm_mailbox u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req), .req_we_i(we), .req_dw_i(1'b1),
      .req_addr_i(addr), .req_wdata_i(wd), .ack_o(ack), .rdata_o(rd), .err_o(err), .busy_o(busy));
   srfm_host_model u_host (.ref_clk_i(ref_clk_i), .ack_i(ack), .rdata_i(rd), .err_i(err),
      .req_o(req), .we_o(we), .addr_o(addr), .wdata_o(wd));
   task stop_test;
      begin
         $display("tests %0d failures %0d", n_tests, failures);
         if (failures == 0 && n_tests > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   // Read data is judged on every read, underruns included, except where the expected error is unmapped
   task op(input w, input [15:0] a, input [31:0] d, input [31:0] xr, input [1:0] xe);
      begin
         u_host.acc(w, a, d, r, e);
         n_tests = n_tests + 1;
         if (e !== xe || (!w && xe != 2'h3 && r !== xr)) begin
            failures = failures + 1;
            $display("BAD access %h exp %h/%h seen %h/%h", a, xr, xe, r, e);
         end
      end
   endtask
   task t_alloc;
      begin
         op(1, `SRFM_ADDR_CAPACITY, 32'h8, 0, 2'h0);
         op(0, `SRFM_ADDR_CAPACITY, 0, 32'h8, 2'h0);
         op(1, `SRFM_ADDR_CAPACITY + 2, 32'h4, 0, 2'h0);
         op(0, `SRFM_ADDR_FILL + 2, 0, 32'h0, 2'h0);
      end
   endtask
   task t_cross;
      begin
         op(1, `SRFM_ADDR_U16_PORT, 32'h1234, 0, 2'h0);
         op(1, `SRFM_ADDR_U16_PORT, 32'h5678, 0, 2'h0);
         op(0, `SRFM_ADDR_FILL, 0, 32'h4, 2'h0);
         op(1, `SRFM_ADDR_I32_PORT, 32'ha5b6c7d8, 0, 2'h0);
         op(1, `SRFM_ADDR_F32_PORT, 32'h1, 0, 2'h2);
         op(0, `SRFM_ADDR_FILL, 0, 32'h8, 2'h0);
         op(0, `SRFM_ADDR_U32_PORT, 0, 32'h12345678, 2'h0);
         op(0, `SRFM_ADDR_U16_PORT, 0, 32'ha5b6, 2'h0);
         op(0, `SRFM_ADDR_F32_PORT, 0, 32'h0, 2'h1);
         op(0, `SRFM_ADDR_U16_PORT, 0, 32'hc7d8, 2'h0);
      end
   endtask
   task t_flush;
      begin
         op(1, `SRFM_ADDR_U32_PORT, 32'h1, 0, 2'h0);
         op(1, `SRFM_ADDR_U32_PORT + 2, 32'h2, 0, 2'h0);
         op(1, `SRFM_ADDR_FLUSH, 32'h0, 0, 2'h0);
         op(0, `SRFM_ADDR_FILL, 0, 32'h0, 2'h0);
         op(0, `SRFM_ADDR_FILL + 2, 0, 32'h4, 2'h0);
         op(0, `SRFM_ADDR_U32_PORT + 2, 0, 32'h2, 2'h0);
         op(0, `SRFM_ADDR_U16_PORT, 0, 32'h0, 2'h1);
         op(1, `SRFM_ADDR_U16_PORT, 32'hbeef, 0, 2'h0);
         op(0, `SRFM_ADDR_U16_PORT, 0, 32'hbeef, 2'h0);
         op(0, `SRFM_ADDR_FLUSH, 0, 0, 2'h3);
         op(1, `SRFM_ADDR_FILL, 32'h5, 0, 2'h3);
         op(0, 16'h0000, 0, 0, 2'h3);
         op(1, `SRFM_ADDR_CAPACITY + 6, 32'h4, 0, 2'h0);
         op(1, `SRFM_ADDR_I32_PORT + 6, 32'h8765_4321, 0, 2'h0);
         op(0, `SRFM_ADDR_FILL + 6, 0, 32'h4, 2'h0);
         op(0, `SRFM_ADDR_F32_PORT + 6, 0, 32'h8765_4321, 2'h0);
         op(1, `SRFM_ADDR_CAPACITY + 4, 32'h1000, 0, 2'h0);
         op(0, `SRFM_ADDR_CAPACITY + 4, 0, 32'h100, 2'h0);
      end
   endtask
   initial begin
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // Whole run needs well under a thousand cycles
   always @(posedge ref_clk_i) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         failures = failures + 1;
         stop_test;
      end
   end
   initial begin
      repeat (20) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_i = 1'b0;
      t_alloc;
      t_cross;
      t_flush;
      stop_test;
   end
endmodule // tb_shared_ram_fifo_mailbox
